// >>> design/i2c_start_pkg.sv
`default_nettype none
package i2c_start_pkg;
	// ==========================================
	// Second control register bit positions
	localparam int START_BIT = 0;
	localparam int RESTART_BIT = 1;
	localparam int STOP_BIT = 2;
	localparam int RCV_BIT = 3;
	localparam int ACKSEQ_BIT = 4;
	localparam int ACKDT_BIT = 5;
	localparam int ACKSTAT_BIT = 6;
	localparam int LOCK_BITS = 5;
	// ==========================================
	// Reset values
	localparam logic [7:0] CON2_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h09;
	localparam logic [7:0] BUF_RESET = 8'h00;
	// ==========================================
	// Timing: two counter phases per instruction cycle
	localparam int CLK_MHZ = 100;
	localparam int TCY_NS = 40;
	localparam int PHASE_NS = TCY_NS / 2;
	localparam int PHASE_CYCLES_RAW = (PHASE_NS * CLK_MHZ) / 1000;
	localparam int PHASE_CYCLES = (PHASE_CYCLES_RAW < 1) ? 1 : PHASE_CYCLES_RAW;
	localparam int BAUD_W = 7;
	localparam int TX_LAST_BIT = 8;
	localparam int RX_LAST_BIT = 7;
	// ==========================================
	// Engine modes
	typedef enum logic [1:0] {X_TX, X_RX, X_ACK} xfer_mode_t;
endpackage
`default_nettype wire

// >>> design/baud_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link between the sequencer and the baud counter
interface baud_if;
	logic load;
	logic [6:0] value;
	logic run;
	logic timeout;
	modport ctrl (output load, output value, output run, input timeout);
	modport cnt (input load, input value, input run, output timeout);
endinterface
`default_nettype wire

// >>> design/baud_counter.sv
`timescale 1ns/10ps
`default_nettype none
module baud_counter (
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	baud_if.cnt bg // Load, run and timeout
);
	import i2c_start_pkg::*;

	logic [7:0] phase_cnt;
	logic tick;
	logic [BAUD_W-1:0] cnt;
	logic active;

	// ==========================================
	// Phase divider: one enable per counter phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (phase_cnt == 8'(PHASE_CYCLES - 1)) begin
			phase_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			phase_cnt <= phase_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// ==========================================
	// count down, halt at zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 7'h00;
			active <= 1'b0;
			bg.timeout <= 1'b0;
		end else begin
			bg.timeout <= 1'b0;
			if (bg.load) begin
				cnt <= bg.value;
				active <= 1'b1;
			end else if (bg.run && active && tick) begin
				if (cnt == 7'h00) begin
					active <= 1'b0;
					bg.timeout <= 1'b1;
				end else begin
					cnt <= cnt - 7'h01;
				end
			end
		end
	end

	baud_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cnt == 7'h00 && !bg.load) |=> (cnt == 7'h00))
		else $error("baud counter left zero without reload");
endmodule
`default_nettype wire

// >>> design/i2c_master_start_baud.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_start_baud (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic scl_in, // SCL line level
	output logic scl_out, // SCL driven value, always low
	output logic scl_oe_n, // SCL drive enable, low pulls line
	input wire logic sda_in, // SDA line level
	output logic sda_out, // SDA driven value, always low
	output logic sda_oe_n, // SDA drive enable, low pulls line
	input wire logic buf_wr, // Transfer buffer write strobe
	input wire logic [7:0] buf_wdata, // Transfer buffer write data
	input wire logic con2_wr, // Second control register write strobe
	input wire logic [7:0] con2_wdata, // Second control register write data
	input wire logic baud_wr, // Address/baud register write strobe
	input wire logic [7:0] baud_wdata, // Address/baud register write data
	input wire logic pif_clr, // Clear interrupt flag
	input wire logic bcl_clr, // Clear collision flag
	input wire logic write_collision_flag_clr, // Clear write collision flag
	output logic [7:0] control_reg_two, // Second control register
	output logic [7:0] transfer_buffer, // Transfer buffer
	output logic [7:0] address_baud_reg, // Address/baud register
	output logic start_seen, // Start detected status
	output logic port_interrupt_flag, // Port interrupt flag
	output logic collision_flag, // Bus collision flag
	output logic write_collision_flag // Write collision flag
);
	import i2c_start_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_ST_CHK, S_ST_HOLD, S_RS_LOW, S_RS_SDA, S_RS_REL, S_RS_HIGH, S_RS_HOLD,
		S_BIT_LOW, S_BIT_REL, S_BIT_HIGH, S_SP_LOW, S_SP_REL, S_SP_HIGH, S_SP_END, S_SETTLE
	} state_t;

	state_t state;
	xfer_mode_t xmode;
	baud_if bg ();
	logic scl_m, scl_s, sda_m, sda_s;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [4:0] cur_mask;
	logic ev_end, ev_pif, ev_bcl, ev_seen, ev_stop, ev_ack, ev_rx, ack_val;
	logic [7:0] rx_byte;
	logic locked, buf_take, last_bit;

	baud_counter u_baud (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.bg(bg.cnt)
	);

	// ==========================================
	// Line synchronisers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			sda_m <= sda_in;
			sda_s <= sda_m;
		end
	end

	// Start and Repeated Start phases lock the five low control bits
	assign locked = (state inside {S_ST_CHK, S_ST_HOLD, S_RS_LOW, S_RS_SDA, S_RS_REL,
		S_RS_HIGH, S_RS_HOLD});
	assign buf_take = buf_wr && (state == S_IDLE) && (control_reg_two[4:0] == 5'h00);
	assign last_bit = (xmode == X_ACK) || (xmode == X_TX && bit_cnt == 4'(TX_LAST_BIT))
		|| (xmode == X_RX && bit_cnt == 4'(RX_LAST_BIT));

	// ==========================================
	// Sequencer: pins, counter control, bit engine
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			xmode <= X_TX;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			bg.load <= 1'b0;
			bg.value <= 7'h00;
			bg.run <= 1'b0;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			cur_mask <= 5'h00;
			rx_byte <= 8'h00;
			{ev_end, ev_pif, ev_bcl, ev_seen, ev_stop, ev_ack, ev_rx, ack_val} <= 8'h00;
		end else begin
			bg.load <= 1'b0;
			{ev_end, ev_pif, ev_bcl, ev_seen, ev_stop, ev_ack, ev_rx} <= 7'h00;
			unique case (state)
				S_IDLE: begin
					bit_cnt <= 4'h0;
					if (control_reg_two[START_BIT]) begin
						cur_mask <= 5'h01;
						// lines not both high at Start
						if (!(scl_s && sda_s)) begin
							ev_bcl <= 1'b1;
							ev_end <= 1'b1;
							state <= S_SETTLE;
						end else begin
							bg.load <= 1'b1;
							bg.value <= address_baud_reg[6:0];
							bg.run <= 1'b1;
							state <= S_ST_CHK;
						end
					end else if (control_reg_two[RESTART_BIT]) begin
						cur_mask <= 5'h02;
						scl_oe_n <= 1'b0;
						state <= S_RS_LOW;
					end else if (control_reg_two[STOP_BIT]) begin
						// Stop begins with both lines low
						cur_mask <= 5'h04;
						scl_oe_n <= 1'b0;
						sda_oe_n <= 1'b0;
						bg.load <= 1'b1;
						bg.value <= address_baud_reg[6:0];
						bg.run <= 1'b1;
						state <= S_SP_LOW;
					end else if (control_reg_two[RCV_BIT] || control_reg_two[ACKSEQ_BIT]
						|| buf_take) begin
						cur_mask <= control_reg_two[RCV_BIT] ? 5'h08 :
							(control_reg_two[ACKSEQ_BIT] ? 5'h10 : 5'h00);
						xmode <= control_reg_two[RCV_BIT] ? X_RX :
							(control_reg_two[ACKSEQ_BIT] ? X_ACK : X_TX);
						// SDA follows one cycle after SCL has fallen
						shift <= buf_wdata;
						scl_oe_n <= 1'b0;
						bg.load <= 1'b1;
						bg.value <= address_baud_reg[6:0];
						bg.run <= 1'b1;
						state <= S_BIT_LOW;
					end
				end
				S_ST_CHK: begin
					if (!scl_s) begin
						{ev_bcl, ev_end, bg.run} <= 3'b110;
						state <= S_SETTLE;
					end else if (bg.timeout) begin
						if (sda_s) begin
							sda_oe_n <= 1'b0;
							ev_seen <= 1'b1;
							bg.load <= 1'b1;
							state <= S_ST_HOLD;
						end else begin
							{ev_bcl, ev_end, bg.run} <= 3'b110;
							state <= S_SETTLE;
						end
					end
				end
				S_ST_HOLD: begin
					if (bg.timeout) begin
						{ev_pif, ev_end, bg.run} <= 3'b110;
						state <= S_SETTLE;
					end
				end
				S_RS_LOW: begin
					if (!scl_s) begin
						sda_oe_n <= 1'b1;
						bg.load <= 1'b1;
						bg.value <= {1'b0, address_baud_reg[5:0]};
						bg.run <= 1'b1;
						state <= S_RS_SDA;
					end
				end
				S_RS_SDA: begin
					if (bg.timeout) begin
						bg.run <= 1'b0;
						if (sda_s) begin
							scl_oe_n <= 1'b1;
							state <= S_RS_REL;
						end else begin
							{ev_bcl, ev_end, scl_oe_n} <= 3'b111;
							state <= S_SETTLE;
						end
					end
				end
				S_RS_REL: begin
					if (scl_s && !sda_s) begin
						{ev_bcl, ev_end} <= 2'b11;
						state <= S_SETTLE;
					end else if (scl_s) begin
						bg.load <= 1'b1;
						bg.value <= address_baud_reg[6:0];
						bg.run <= 1'b1;
						state <= S_RS_HIGH;
					end
				end
				S_RS_HIGH: begin
					if (!scl_s || !sda_s) begin
						{ev_bcl, ev_end, bg.run} <= 3'b110;
						state <= S_SETTLE;
					end else if (bg.timeout) begin
						sda_oe_n <= 1'b0;
						ev_seen <= 1'b1;
						bg.load <= 1'b1;
						state <= S_RS_HOLD;
					end
				end
				S_RS_HOLD: begin
					if (bg.timeout) begin
						{ev_pif, ev_end, bg.run} <= 3'b110;
						state <= S_SETTLE;
					end
				end
				S_BIT_LOW: begin
					// data moves only while SCL is low
					if (xmode == X_TX) begin
						sda_oe_n <= (bit_cnt == 4'(TX_LAST_BIT)) ? 1'b1 : shift[7];
					end else begin
						// receive releases, ack pulse drives ack data
						sda_oe_n <= (xmode == X_RX) || control_reg_two[ACKDT_BIT];
					end
					if (bg.timeout) begin
						scl_oe_n <= 1'b1;
						bg.run <= 1'b0;
						state <= S_BIT_REL;
					end
				end
				S_BIT_REL: begin
					// wait for SCL high, then reload
					if (scl_s) begin
						bg.load <= 1'b1;
						bg.run <= 1'b1;
						state <= S_BIT_HIGH;
					end
				end
				S_BIT_HIGH: begin
					// second rollover ends the SCL period
					if (bg.timeout) begin
						scl_oe_n <= 1'b0;
						shift <= {shift[6:0], sda_s};
						if (last_bit) begin
							{ev_pif, ev_end, bg.run} <= 3'b110;
							// ninth clock sample is the ack
							ev_ack <= (xmode == X_TX);
							ack_val <= sda_s;
							ev_rx <= (xmode == X_RX);
							rx_byte <= {shift[6:0], sda_s};
							if (xmode == X_TX) begin
								sda_oe_n <= 1'b1;
							end
							state <= S_SETTLE;
						end else begin
							// Next bit: low phase starts again
							bit_cnt <= bit_cnt + 4'h1;
							bg.load <= 1'b1;
							state <= S_BIT_LOW;
						end
					end
				end
				S_SP_LOW: begin
					if (bg.timeout) begin
						scl_oe_n <= 1'b1;
						bg.run <= 1'b0;
						state <= S_SP_REL;
					end
				end
				S_SP_REL: begin
					if (scl_s) begin
						bg.load <= 1'b1;
						bg.run <= 1'b1;
						state <= S_SP_HIGH;
					end
				end
				S_SP_HIGH: begin
					// releasing SDA with SCL high frees the bus
					if (bg.timeout) begin
						sda_oe_n <= 1'b1;
						bg.load <= 1'b1;
						state <= S_SP_END;
					end
				end
				S_SP_END: begin
					if (bg.timeout) begin
						{ev_pif, ev_end, ev_stop, bg.run} <= 4'b1110;
						state <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Second control register and baud register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg_two <= CON2_RESET;
			address_baud_reg <= BAUD_RESET;
		end else begin
			if (baud_wr) begin
				address_baud_reg <= baud_wdata;
			end
			if (con2_wr) begin
				control_reg_two[ACKDT_BIT] <= con2_wdata[ACKDT_BIT];
				// low bits frozen during Start phases
				if (!locked) begin
					control_reg_two[START_BIT] <= con2_wdata[START_BIT];
					control_reg_two[STOP_BIT] <= con2_wdata[STOP_BIT];
					control_reg_two[ACKSEQ_BIT] <= con2_wdata[ACKSEQ_BIT];
					// restart and receive only from idle
					if (state == S_IDLE) begin
						control_reg_two[RESTART_BIT] <= con2_wdata[RESTART_BIT];
						control_reg_two[RCV_BIT] <= con2_wdata[RCV_BIT];
					end
				end
			end
			if (ev_end) begin
				control_reg_two[LOCK_BITS-1:0] <= control_reg_two[LOCK_BITS-1:0] & ~cur_mask;
			end
			if (ev_ack) begin
				control_reg_two[ACKSTAT_BIT] <= ack_val;
			end
		end
	end

	// ==========================================
	// Status flags: set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_interrupt_flag <= 1'b0;
			collision_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			port_interrupt_flag <= ev_pif || (port_interrupt_flag && !pif_clr);
			collision_flag <= ev_bcl || (collision_flag && !bcl_clr);
			write_collision_flag <= (buf_wr && !buf_take) || (write_collision_flag && !write_collision_flag_clr);
			// status as soon as Start appears
			start_seen <= ev_seen || (start_seen && !ev_stop);
		end
	end

	// ==========================================
	// Transfer buffer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_buffer <= BUF_RESET;
		end else if (buf_take) begin
			transfer_buffer <= buf_wdata;
		end else if (ev_rx) begin
			// received byte lands in the buffer
			transfer_buffer <= rx_byte;
		end
	end

	// ==========================================
	// Checks
	write_collision_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(buf_wr && locked) |=> write_collision_flag)
		else $error("write during start not flagged");
	buf_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(buf_wr && locked && !ev_rx) |=> $stable(transfer_buffer))
		else $error("buffer changed by refused write");
	con2_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(con2_wr && locked && !ev_end) |=> (control_reg_two[4:0] == $past(control_reg_two[4:0])))
		else $error("locked control bits changed");
	restart_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(con2_wr && con2_wdata[1] && state != S_IDLE && !control_reg_two[1])
		|=> !control_reg_two[1])
		else $error("restart accepted while busy");
	start_coll_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == S_IDLE && control_reg_two[0] && !(scl_s && sda_s)) |=> ev_bcl ##1 collision_flag)
		else $error("start collision not flagged");
	start_sda_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == S_ST_CHK && bg.timeout && scl_s && sda_s) |=> !sda_oe_n ##1 start_seen)
		else $error("start condition not driven");
	scl_stretch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == S_BIT_REL && !scl_s) |=> (!bg.run && state == S_BIT_REL))
		else $error("counter ran while SCL held low");
	tx_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == S_BIT_HIGH && xmode == X_TX && bit_cnt == 4'h8 && bg.timeout)
		|=> ##1 (control_reg_two[6] == $past(sda_s, 2)) && port_interrupt_flag)
		else $error("ack status or interrupt wrong");
endmodule
`default_nettype wire

// >>> testbench/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Behavioural slave on the far side of the two lines
module i2c_slave_model (
	input wire logic scl, // Resolved SCL level
	input wire logic sda, // Resolved SDA level
	input wire logic nack, // Refuse the next written byte
	input wire logic [7:0] rd_byte, // Byte returned in read mode
	input wire logic [9:0] stretch_ns, // Low hold after each fall
	output logic sda_pull, // High pulls SDA low
	output logic scl_pull, // High pulls SCL low
	output logic [7:0] got_byte // Last byte taken from the master
);
	logic [7:0] sh;
	logic armed, addr, rd;
	int cnt;
	// Idle, lines released
	initial begin
		{sda_pull, scl_pull, armed, addr, rd, got_byte, sh} = '0;
		cnt = 0;
	end
	// Start and stop detection
	always @(negedge sda) if (scl) begin
		{armed, rd} = '0;
		cnt = 0;
		addr = 1;
	end
	always @(posedge sda) if (scl) begin
		{armed, rd, addr} = '0;
	end
	// Sample master bits on rising SCL
	always @(posedge scl) if (!rd && cnt < 8) begin
		sh = {sh[6:0], sda};
	end
	// a refused read byte ends the slave's drive
	always @(posedge scl) if (rd && cnt == 8) begin
		rd = !sda;
	end
	// Byte count, acknowledge and read data after each fall
	always @(negedge scl) begin
		#1;
		if (!armed) begin
			armed = 1;
		end else begin
			cnt++;
			if (cnt == 9) begin
				cnt = 0;
				rd = rd | (addr & got_byte[0]);
				addr = 0;
			end
			if (cnt == 8) begin
				if (!rd) got_byte = sh;
				sda_pull = !rd && !nack;
			end else if (rd) begin
				sda_pull = !rd_byte[7 - cnt];
			end else begin
				sda_pull = 0;
			end
		end
	end
	// Clock stretching, hold SCL low a while after each fall
	always @(negedge scl) if (stretch_ns != 0) begin
		scl_pull = 1;
		#(stretch_ns);
		scl_pull = 0;
	end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import i2c_start_pkg::*;
	logic sys_clk, rst_n, buf_wr, con2_wr, baud_wr, pif_clr, bcl_clr, write_collision_flag_clr;
	logic [7:0] buf_wdata, con2_wdata, baud_wdata, control_reg_two, transfer_buffer;
	logic [7:0] address_baud_reg, got_byte, rd_byte, v, w, old;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, start_seen, port_interrupt_flag;
	logic collision_flag, write_collision_flag, sda_pull, scl_pull, nack, tb_sda, tb_scl, measure;
	logic [9:0] stretch_ns;
	wire logic scl_line, sda_line;
	int fails, comparisons, seed, reload, lo, pos_cnt, k;
	realtime t_hi;
	// Open-drain lines with pull-ups
	assign scl_line = !((!scl_oe_n && !scl_out) || scl_pull || tb_scl);
	assign sda_line = !((!sda_oe_n && !sda_out) || sda_pull || tb_sda);
	i2c_master_start_baud i_i2c_master_start_baud (.sys_clk(sys_clk), .rst_n(rst_n),
		.scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
		.con2_wr(con2_wr), .con2_wdata(con2_wdata), .baud_wr(baud_wr),
		.baud_wdata(baud_wdata), .pif_clr(pif_clr), .bcl_clr(bcl_clr), .write_collision_flag_clr(write_collision_flag_clr),
		.control_reg_two(control_reg_two), .transfer_buffer(transfer_buffer),
		.address_baud_reg(address_baud_reg), .start_seen(start_seen),
		.port_interrupt_flag(port_interrupt_flag), .collision_flag(collision_flag),
		.write_collision_flag(write_collision_flag));
	i2c_slave_model i_i2c_slave_model (.scl(scl_line), .sda(sda_line), .nack(nack),
		.rd_byte(rd_byte), .stretch_ns(stretch_ns), .sda_pull(sda_pull),
		.scl_pull(scl_pull), .got_byte(got_byte));
	// 100 MHz clock
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Time each SCL high phase of a byte
	always @(posedge scl_line) begin
		t_hi = measure ? $realtime : -1.0;
		if (measure) pos_cnt++;
	end
	always @(negedge scl_line) if (measure && t_hi >= 0) begin
		k = int'($realtime - t_hi);
		chk("scl_high_time", 8'h01, {7'h00, k >= lo && k <= lo + 80});
	end
	// One strobe cycle: 0 buffer, 1 control, 2 baud
	task automatic wr(input int which, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		buf_wr = (which == 0);
		con2_wr = (which == 1);
		baud_wr = (which == 2);
		{buf_wdata, con2_wdata, baud_wdata} = {3{d}};
		@(posedge sys_clk);
		#1;
		{buf_wr, con2_wr, baud_wr} = '0;
	endtask
	task automatic clr();
		@(posedge sys_clk);
		#1;
		{pif_clr, bcl_clr, write_collision_flag_clr} = 3'h7;
		@(posedge sys_clk);
		#1;
		{pif_clr, bcl_clr, write_collision_flag_clr} = '0;
		chk("flags_clear", 8'h00, {5'h00, port_interrupt_flag, collision_flag, write_collision_flag});
	endtask
	task automatic wait_flag(input int lim);
		while (port_interrupt_flag !== 1'b1 && lim > 0) begin
			@(posedge sys_clk);
			#1;
			lim--;
		end
		chk("flag_raised", 8'h01, {7'h00, port_interrupt_flag});
		repeat (4) @(posedge sys_clk);
		#1;
		chk("flag_held", 8'h01, {7'h00, port_interrupt_flag});
	endtask
	// Send one byte, optionally asking for a restart mid-byte
	task automatic send(input logic [7:0] d, input logic refuse, input logic try_rs);
		clr();
		nack = refuse;
		pos_cnt = 0;
		measure = 1;
		wr(0, d);
		chk("buffer", d, transfer_buffer);
		if (try_rs) begin
			repeat (30) @(posedge sys_clk);
			wr(1, 8'h02);
			chk("restart_ignored", 8'h00, {7'h00, control_reg_two[RESTART_BIT]});
		end
		wait_flag(3000);
		measure = 0;
		chk("pulses", 8'h09, 8'(pos_cnt));
		chk("byte_sent", d, got_byte);
		chk("ack_status", {7'h00, refuse}, {7'h00, control_reg_two[ACKSTAT_BIT]});
	endtask
	// Hang guard
	initial begin
		#600000;
		fails++;
		$display("MISMATCH watchdog expected done seen running");
		print_verdict();
	end
	// Main sequence
	initial begin
		{buf_wr, con2_wr, baud_wr, pif_clr, bcl_clr, write_collision_flag_clr, tb_sda, tb_scl} = '0;
		{buf_wdata, con2_wdata, baud_wdata, rd_byte, nack, measure, stretch_ns} = '0;
		{fails, comparisons, pos_cnt, lo} = '0;
		t_hi = -1.0;
		seed = 89;
		rst_n = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		rst_n = 1;
		chk("control_reset", CON2_RESET, control_reg_two);
		chk("baud_reset", BAUD_RESET, address_baud_reg);
		chk("buffer_reset", BUF_RESET, transfer_buffer);
		chk("flags_reset", 8'h00, {4'h0, start_seen, port_interrupt_flag, collision_flag, write_collision_flag});
		for (int r = 0; r < 3; r++) begin
			v = 8'($random(seed));
			w = 8'($random(seed));
			reload = 2 + v[2:0];
			lo = (reload + 1) * PHASE_CYCLES * 10;
			stretch_ns = 10'(125 * v[4:3]);
			wr(2, {v[7], 7'(reload)});
			chk("baud", {v[7], 7'(reload)}, address_baud_reg);
			clr();
			old = transfer_buffer;
			wr(1, 8'h01);
			wr(0, ~old);
			wr(1, 8'h04);
			chk("write_collision", 8'h01, {7'h00, write_collision_flag});
			chk("buffer_kept", old, transfer_buffer);
			wait_flag(1000);
			chk("start_ctrl", 8'h00, {3'h0, control_reg_two[4:0]});
			chk("start_state", 8'h06, {5'h00, start_seen, scl_line, sda_line});
			send({w[6:0], 1'b0}, 1'b0, 1'b0);
			send(8'($random(seed)), 1'b1, 1'b1);
			clr();
			wr(1, 8'h02);
			wait_flag(1000);
			chk("restart_state", 8'h06, {5'h00, start_seen, scl_line, sda_line});
			chk("restart_bit", 8'h00, {7'h00, control_reg_two[RESTART_BIT]});
			rd_byte = 8'($random(seed));
			send({w[6:0], 1'b1}, 1'b0, 1'b0);
			clr();
			pos_cnt = 0;
			measure = 1;
			wr(1, 8'h08);
			wait_flag(3000);
			measure = 0;
			chk("rx_pulses", 8'h08, 8'(pos_cnt));
			chk("rx_byte", rd_byte, transfer_buffer);
			// Refusing acknowledge after the received byte
			clr();
			pos_cnt = 0;
			measure = 1;
			wr(1, 8'h30);
			wait_flag(1000);
			measure = 0;
			chk("ack_pulses", 8'h01, 8'(pos_cnt));
			chk("ack_done", 8'h81, {control_reg_two[5:0], scl_line, sda_line});
			clr();
			wr(1, 8'h04);
			wait_flag(1000);
			chk("stop_state", 8'h03, {5'h00, start_seen, scl_line, sda_line});
			chk("stop_bit", 8'h00, {7'h00, control_reg_two[STOP_BIT]});
		end
		// Start or Repeated Start against a line held low by another master
		for (int c = 0; c < 3; c++) begin
			clr();
			tb_sda = (c != 1);
			tb_scl = (c == 1);
			repeat (4) @(posedge sys_clk);
			wr(1, (c == 2) ? 8'h02 : 8'h01);
			k = 0;
			while (collision_flag !== 1'b1 && k < 1000) begin
				@(posedge sys_clk);
				#1;
				k++;
			end
			chk("collision", 8'h01, {7'h00, collision_flag});
			chk("start_aborted", 8'h01,
				{6'h00, control_reg_two[(c == 2) ? RESTART_BIT : START_BIT], sda_oe_n});
			{tb_sda, tb_scl} = '0;
		end
		clr();
		print_verdict();
	end
endmodule
`default_nettype wire
